// >>> iemr_top.sv
// invalidation event message registers with ahb-lite access and message write generation
//
// Overview of operation
// - data register reads zero without queued invalidation
// - upper data bits valid only with 32-bit data
// - 16-bit-only data: upper bits read zero
// - data bits 15:0 go into message payload
// - address register reads zero without queued invalidation
// - message address bits 31:2 stored, 1:0 zero
// - upper address fully stored with both features
// - upper address reads zero lacking either feature
// - unmasked event sends message from these registers
// - no message while mask set (a write already started still runs to its ack); mask resets set
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "iemr_cfg.svh"
module iemr_top #(
  parameter bit QI_SUPPORT = 1'b1, // queued invalidation supported
  parameter bit EIM_SUPPORT = 1'b1, // extended interrupt mode supported
  parameter bit DATA32_SUPPORT = 1'b1 // 32-bit interrupt message data supported
) (
  input wire logic hclk, // clock, 250 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [11:0] haddr, // ahb byte address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, only words used
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  input wire logic inval_event, // one-cycle pulse: wait descriptor with interrupt completed
  input wire logic msg_ack, // fabric accepted the message write
  output logic msg_valid, // message write request
  output logic [63:0] msg_addr, // message target address
  output logic [31:0] msg_data, // message payload
  output logic irq // level interrupt of unmasked status bits
);
  wire wr_en; // data phase write strobe
  wire rd_en; // data phase read strobe
  wire [11:0] acc_addr; // latched word address
  wire sent_pulse; // message write accepted
  wire send_valid; // sender request
  wire qi_on = QI_SUPPORT; // queued invalidation present
  wire eim_on = QI_SUPPORT & EIM_SUPPORT; // both features present

  iemr_pkg::iemr_word_t data_reg; // message data storage
  iemr_pkg::iemr_word_t addr_reg; // message low address storage
  iemr_pkg::iemr_word_t uaddr_reg; // message upper address storage
  logic mask_reg; // event mask, resets set
  logic pend_reg; // event waiting for delivery
  logic [`IEMR_NUM_EVENTS-1:0] istat_reg; // sticky status: sent, dropped-while-busy
  logic [`IEMR_NUM_EVENTS-1:0] imask_reg; // status interrupt enables
  logic [`IEMR_NUM_EVENTS-1:0] ev_set; // status set sources

  // register bus front end
  iemr_ahb_slave u_slave (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .acc_addr(acc_addr)
  );

  // message sender
  iemr_msg_gen u_gen (
    .hclk(hclk),
    .hresetn(hresetn),
    .pending(pend_reg),
    .masked(mask_reg),
    .msg_ack(msg_ack),
    .msg_valid(send_valid),
    .sent(sent_pulse)
  );

  // register write decode
  wire wr_ctrl = wr_en & (acc_addr == `IEMR_OFF_CTRL);
  wire wr_data = wr_en & (acc_addr == `IEMR_OFF_DATA) & qi_on;
  wire wr_addr = wr_en & (acc_addr == `IEMR_OFF_ADDR) & qi_on;
  wire wr_uaddr = wr_en & (acc_addr == `IEMR_OFF_UADDR) & eim_on;
  wire wr_istat = wr_en & (acc_addr == `IEMR_OFF_ISTAT);
  wire wr_imask = wr_en & (acc_addr == `IEMR_OFF_IMASK);

  // write masks: upper data half kept only when 32-bit data is supported
  wire [31:0] data_keep = DATA32_SUPPORT ? 32'hFFFF_FFFF : `IEMR_DATA_LOW_KEEP;
  wire [31:0] data_wval = hwdata & data_keep;
  wire [31:0] addr_wval = hwdata & `IEMR_ADDR_LOW_KEEP;

  // event bookkeeping: a second event while one is pending merges and is reported as dropped
  assign ev_set[`IEMR_ISTAT_SENT_BIT] = sent_pulse;
  assign ev_set[`IEMR_ISTAT_DROP_BIT] = inval_event & pend_reg & qi_on;
  wire pend_next = qi_on & ((pend_reg & ~sent_pulse) | inval_event); // new event beats the clear

  // control register readback: mask in bit 31, pending in bit 30
  wire [31:0] ctrl_rd = qi_on ? {mask_reg, pend_reg, 30'h0000_0000} : 32'h0000_0000;

  // read mux works on the live address phase so the registered word stands for the whole data phase
  wire [11:0] rd_addr = {haddr[11:2], 2'b00}; // word address of the read being taken
  wire rd_take = hsel & hready & htrans[1] & ~hwrite; // read address phase accepted
  // read mux; unmapped offsets read zero
  wire [31:0] rd_mux =
    (rd_addr == `IEMR_OFF_CTRL) ? ctrl_rd :
    (rd_addr == `IEMR_OFF_DATA) ? data_reg :
    (rd_addr == `IEMR_OFF_ADDR) ? addr_reg :
    (rd_addr == `IEMR_OFF_UADDR) ? uaddr_reg :
    (rd_addr == `IEMR_OFF_ISTAT) ? {30'h0000_0000, istat_reg} :
    (rd_addr == `IEMR_OFF_IMASK) ? {30'h0000_0000, imask_reg} :
    32'h0000_0000;

  // next irq level: any unmasked sticky bit
  wire irq_next = |(istat_reg & imask_reg);

  // message register storage, zero after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= `IEMR_RST_WORD;
      addr_reg <= `IEMR_RST_WORD;
      uaddr_reg <= `IEMR_RST_WORD;
    end else begin
      if (wr_data) begin
        data_reg <= data_wval;
      end
      if (wr_addr) begin
        addr_reg <= addr_wval;
      end
      if (wr_uaddr) begin
        uaddr_reg <= hwdata;
      end
    end
  end

  // mask and pending; mask comes out of reset set so nothing is sent before software is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= `IEMR_RST_MASK;
      pend_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mask_reg <= hwdata[`IEMR_CTRL_MASK_BIT] | ~qi_on;
      end
      pend_reg <= pend_next;
    end
  end

  // sticky status bits, write one to clear, a same-cycle set wins
  genvar gi;
  generate
    for (gi = 0; gi < `IEMR_NUM_EVENTS; gi = gi + 1) begin : g_stat
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          istat_reg[gi] <= 1'b0;
          imask_reg[gi] <= 1'b0;
        end else begin
          istat_reg[gi] <= ev_set[gi] | (istat_reg[gi] & ~(wr_istat & hwdata[gi]));
          if (wr_imask) begin
            imask_reg[gi] <= hwdata[gi];
          end
        end
      end
    end
  endgenerate

  // bus outputs: zero wait states, okay response, read data valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // limitation: a read issued in the data phase of a write to the same word returns the old value
      hrdata <= rd_take ? rd_mux : hrdata;
    end
  end

  // message outputs; address and payload snapshot the registers as the request rises
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_addr <= 64'h0000_0000_0000_0000;
      msg_data <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
      // track the registers while idle; the value of the edge on which the request rises is held
      if (~send_valid) begin
        msg_addr <= {uaddr_reg, addr_reg[31:2], 2'b00};
        msg_data <= data_reg;
      end
    end
  end

  // request comes straight from the sender's flop; an extra stage here would outlive the accept
  assign msg_valid = send_valid;
  wire unused_rd = rd_en; // read data is registered in the address phase instead
  wire unused_hsize = |hsize; // only whole words are transferred
endmodule

// >>> iemr_cfg.svh
// offsets, field positions, reset values and timing counts for the invalidation event message registers
`ifndef IEMR_CFG_SVH
`define IEMR_CFG_SVH
`define IEMR_OFF_CTRL 12'h0A0
`define IEMR_OFF_DATA 12'h0A4
`define IEMR_OFF_ADDR 12'h0A8
`define IEMR_OFF_UADDR 12'h0AC
`define IEMR_OFF_ISTAT 12'h0B0
`define IEMR_OFF_IMASK 12'h0B4
`define IEMR_CTRL_MASK_BIT 31
`define IEMR_CTRL_PEND_BIT 30
`define IEMR_ISTAT_SENT_BIT 0
`define IEMR_ISTAT_DROP_BIT 1
`define IEMR_NUM_EVENTS 2
`define IEMR_RST_WORD 32'h0000_0000
`define IEMR_RST_MASK 1'b1
`define IEMR_ADDR_LOW_KEEP 32'hFFFF_FFFC
`define IEMR_DATA_LOW_KEEP 32'h0000_FFFF
`define IEMR_MSG_HOLD_CYCLES 1
`endif

// >>> iemr_pkg.sv
// types shared by the invalidation event message register files
package iemr_pkg;
  typedef enum logic [2:0] {
    IEMR_IDLE = 3'b001,
    IEMR_SEND = 3'b010,
    IEMR_WAIT = 3'b100
  } iemr_msg_state_t;
  typedef logic [31:0] iemr_word_t;
endpackage

// >>> iemr_ahb_slave.sv
// ahb-lite slave front end: captures the address phase, answers with zero wait states
`timescale 1ns/1ps
`include "iemr_cfg.svh"
module iemr_ahb_slave (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [11:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready in
  output logic wr_en, // one-cycle write strobe in data phase
  output logic rd_en, // one-cycle read strobe in data phase
  output logic [11:0] acc_addr // word address latched in address phase
);
  // an active transfer is a nonseq or seq cycle taken while the bus is ready
  wire take_xfer = hsel & hready & htrans[1];
  // address phase capture; data phase strobes follow one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      acc_addr <= 12'h000;
    end else begin
      wr_en <= take_xfer & hwrite;
      rd_en <= take_xfer & ~hwrite;
      if (take_xfer) begin
        acc_addr <= {haddr[11:2], 2'b00}; // word aligned only
      end
    end
  end
endmodule

// >>> iemr_msg_gen.sv
// message sender: issues one interrupt write per pending event while unmasked
`timescale 1ns/1ps
`include "iemr_cfg.svh"
module iemr_msg_gen (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic pending, // event waiting to be sent
  input wire logic masked, // event mask set
  input wire logic msg_ack, // fabric accepted the write
  output logic msg_valid, // write request to the fabric
  output logic sent // one-cycle pulse when a write is accepted
);
  iemr_pkg::iemr_msg_state_t state_reg; // sender state
  iemr_pkg::iemr_msg_state_t state_next; // next sender state
  // sender next state; a set mask parks the request before it starts
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      iemr_pkg::IEMR_IDLE: begin
        if (pending && !masked) begin
          state_next = iemr_pkg::IEMR_SEND;
        end
      end
      iemr_pkg::IEMR_SEND: begin
        if (msg_ack) begin
          state_next = iemr_pkg::IEMR_WAIT;
        end
      end
      iemr_pkg::IEMR_WAIT: begin
        state_next = iemr_pkg::IEMR_IDLE; // one cycle gap lets pending clear
      end
      default: begin
        state_next = iemr_pkg::IEMR_IDLE;
      end
    endcase
  end
  // state and outputs; once started a write runs to its ack so the fabric sees no retraction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= iemr_pkg::IEMR_IDLE;
      msg_valid <= 1'b0;
      sent <= 1'b0;
    end else begin
      state_reg <= state_next;
      msg_valid <= (state_next == iemr_pkg::IEMR_SEND);
      sent <= (state_reg == iemr_pkg::IEMR_SEND) & msg_ack;
    end
  end
endmodule

// >>> iemr_top_sva.sv
// port-level assertions for the invalidation event message block
`timescale 1ns/1ps
module iemr_chk #(
  parameter bit QI_SUPPORT = 1'b1, // queued invalidation present
  parameter bit EIM_SUPPORT = 1'b1, // extended irq mode present
  parameter bit DATA32_SUPPORT = 1'b1 // 32-bit message data present
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [11:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic hready, // bus ready
  input wire logic [31:0] hwdata, // write data
  input wire logic [31:0] hrdata, // read data
  input wire logic msg_ack, // fabric accept
  input wire logic msg_valid, // message request
  input wire logic [63:0] msg_addr, // message target
  input wire logic [31:0] msg_data // message payload
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire aph = hsel && hready && htrans[1]; // address phase taken
  logic [11:0] wa_reg; // address of the write now in its data phase
  logic rd_reg; // data phase of a low address read
  logic ctl_reg; // control word written since reset
  logic [31:0] dat_sh, adr_sh, upr_sh; // shadows of what software wrote
  // shadows follow the bus so message contents can be tied to writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_reg <= 12'h000;
      rd_reg <= 1'b0;
      ctl_reg <= 1'b0;
      dat_sh <= 32'h0;
      adr_sh <= 32'h0;
      upr_sh <= 32'h0;
    end else begin
      wa_reg <= (aph && hwrite) ? haddr : 12'h000;
      rd_reg <= aph && !hwrite && haddr == 12'h0A8;
      ctl_reg <= ctl_reg || (aph && hwrite && haddr == 12'h0A0);
      if (wa_reg == 12'h0A4) dat_sh <= hwdata;
      if (wa_reg == 12'h0A8) adr_sh <= hwdata;
      if (wa_reg == 12'h0AC) upr_sh <= hwdata;
    end
  end
  sequence s_held;
    msg_valid && !msg_ack;
  endsequence
  sequence s_same;
    msg_valid && $stable(msg_addr) && $stable(msg_data);
  endsequence
  chk_msg_held: assert property (s_held |=> s_same)
    else $error("message dropped or changed before accept");
  chk_mask_reset: assert property (!ctl_reg |-> !msg_valid)
    else $error("message sent while mask still at reset value");
  chk_addr_dword: assert property (msg_valid |-> msg_addr[1:0] == 2'h0)
    else $error("message address not dword aligned");
  chk_rsvd_read: assert property (rd_reg |-> hrdata[1:0] == 2'h0)
    else $error("low address bits read nonzero");
  chk_msg_payload: assert property (msg_valid |-> msg_data[15:0] == dat_sh[15:0])
    else $error("payload differs from data register");
  chk_msg_target: assert property (msg_valid |-> msg_addr[63:2] == {upr_sh, adr_sh[31:2]})
    else $error("target differs from address registers");
  chk_no_queue: assert property (QI_SUPPORT || (msg_data == 32'h0 && msg_addr[31:0] == 32'h0))
    else $error("registers live without queued invalidation");
  chk_data_narrow: assert property (DATA32_SUPPORT || msg_data[31:16] == 16'h0)
    else $error("upper data bits live on 16-bit build");
endmodule

// >>> iemr_fabric.sv
// far-side model: accepts message writes after a programmable stall
`timescale 1ns/1ps
module iemr_fabric (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic [3:0] stall, // cycles to hold off
  input wire logic msg_valid, // write request
  input wire logic [63:0] msg_addr, // write target
  input wire logic [31:0] msg_data, // write payload
  output logic msg_ack, // accept
  output logic [63:0] got_addr, // last target taken
  output logic [31:0] got_data, // last payload taken
  output int got_cnt // writes taken
);
  logic [3:0] wait_reg; // cycles the request has waited
  // ack drops after one accept so a request is never counted twice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_ack <= 1'b0;
      wait_reg <= 4'h0;
      got_cnt <= 0;
      got_addr <= 64'h0;
      got_data <= 32'h0;
    end else if (msg_valid && msg_ack) begin
      got_addr <= msg_addr;
      got_data <= msg_data;
      got_cnt <= got_cnt + 1;
      msg_ack <= 1'b0;
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= msg_valid ? wait_reg + 4'h1 : 4'h0;
      msg_ack <= msg_valid && wait_reg >= stall; // slow or prompt answer
    end
  end
endmodule

// >>> testbench.sv
// self-checking bench for the invalidation event message registers
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, inval_event = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, msg_data, got_data, q, d, a, u, seed = 32'hC93D;
  logic hreadyout, hresp, msg_ack, msg_valid, irq;
  logic [63:0] msg_addr, got_addr;
  logic [3:0] stall = 4'h3;
  int got_cnt, fails = 0, tests_run = 0, vcnt = 0;
  wire hready = hreadyout; // the one slave drives bus ready
  always #2 hclk = ~hclk; // 250 MHz
  always @(posedge hclk) if (msg_valid === 1'b1) vcnt++; // request cycles seen
  iemr_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .inval_event(inval_event), .msg_ack(msg_ack),
    .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data), .irq(irq));
  iemr_fabric fab (.hclk(hclk), .hresetn(hresetn), .stall(stall), .msg_valid(msg_valid),
    .msg_addr(msg_addr), .msg_data(msg_data), .msg_ack(msg_ack), .got_addr(got_addr),
    .got_data(got_data), .got_cnt(got_cnt));
  // repeatable random words
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // where the message must land: upper word over the dword-aligned low word
  function automatic logic [63:0] target(input logic [31:0] hi, input logic [31:0] lo);
    return {hi, lo[31:2], 2'b00};
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one ahb single transfer; read data lands in q
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic pulse_wait(input int n);
    @(posedge hclk);
    inval_event <= 1'b1;
    @(posedge hclk);
    inval_event <= 1'b0;
    for (int k = 0; k < 200 && got_cnt < n; k++) @(posedge hclk); // bounded wait
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 12'h0B0 - 12'(4 * i), 32'h0);
      check("reset word", q & 32'h7FFF_FFFF, 32'h0);
    end
    check("mask at reset", q[31], 1'b1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = (i == 0) ? 32'hFFFF_FFFF : seed;
      seed = xs(seed);
      a = (i == 0) ? 32'hFFFF_FFFF : seed;
      seed = xs(seed);
      u = seed;
      bus(1'b1, 12'h0A4, d);
      bus(1'b1, 12'h0A8, a);
      bus(1'b1, 12'h0AC, u);
      bus(1'b0, 12'h0A4, 32'h0);
      check("data word", q, d);
      bus(1'b0, 12'h0A8, 32'h0);
      check("low address", q, a & 32'hFFFF_FFFC);
      bus(1'b0, 12'h0AC, 32'h0);
      check("high address", q, u);
    end
    bus(1'b0, 12'h0FC, 32'h0);
    check("unmapped word", q, 32'h0);
    pulse_wait(1);
    check("masked requests", vcnt, 0);
    bus(1'b1, 12'h0B4, 32'h1);
    bus(1'b1, 12'h0A0, 32'h0);
    for (int k = 0; k < 200 && got_cnt < 1; k++) @(posedge hclk);
    check("first target", got_addr, target(u, a));
    check("first payload", got_data, d);
    bus(1'b0, 12'h0B0, 32'h0);
    check("sent flag", q[0], 1'b1);
    check("irq raised", irq, 1'b1);
    bus(1'b1, 12'h0B4, 32'h0);
    repeat (2) @(posedge hclk);
    check("irq masked", irq, 1'b0);
    bus(1'b1, 12'h0B4, 32'h1);
    bus(1'b1, 12'h0B0, 32'h3);
    repeat (2) @(posedge hclk);
    check("irq cleared", irq, 1'b0);
    stall <= 4'h0;
    pulse_wait(2);
    check("second target", got_addr, target(u, a));
    bus(1'b1, 12'h0A0, 32'h8000_0000);
    pulse_wait(0);
    pulse_wait(0);
    bus(1'b0, 12'h0B0, 32'h0);
    check("merged event flag", q[1], 1'b1);
    bus(1'b0, 12'h0A0, 32'h0);
    check("pending held masked", q[31:30], 2'h3);
    check("okay response", {hreadyout, hresp}, 2'h2);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    summarize();
  end
endmodule
bind iemr_top iemr_chk #(.QI_SUPPORT(QI_SUPPORT), .EIM_SUPPORT(EIM_SUPPORT), .DATA32_SUPPORT(DATA32_SUPPORT))
  chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .msg_ack(msg_ack), .msg_valid(msg_valid),
  .msg_addr(msg_addr), .msg_data(msg_data));
